// ---- verif/rcsq_bb_model.sv ----
// Baseband controller model driving the sequencer's control lines.
// Assumes the bench calls drive() and hold_data() between its checks.
`timescale 1ns/100ps
module rcsq_bb_model (
    input wire logic clk,
    input wire logic bidir_data_line_o,
    input wire logic bidir_data_line_oe,
    output logic power_on_request,
    output logic osc_enable_request,
    output logic bidir_data_line_i,
    output logic packet_control,
    output logic rx_raw_data
);
    // Baseband wait before data flows, 175 us at 50 ns a cycle
    localparam int DATA_WAIT_CYC = 3500;
    logic data_drv_r; // Level the baseband puts on the shared line
    // Shared line: the device wins while it drives, else the baseband
    assign bidir_data_line_i = bidir_data_line_oe ? bidir_data_line_o : data_drv_r;
    initial begin
        power_on_request = 1'b0;
        osc_enable_request = 1'b0;
        packet_control = 1'b0;
        data_drv_r = 1'b0;
        rx_raw_data = 1'b0;
    end
    // Demodulated data changes every cycle so a stale copy cannot pass
    always @(posedge clk) begin
        rx_raw_data <= ~rx_raw_data;
    end
    // Baseband changes its lines only just after rising edges
    task automatic drive(input logic p, input logic o, input logic d, input logic k);
        @(posedge clk);
        power_on_request <= p;
        osc_enable_request <= o;
        data_drv_r <= d;
        packet_control <= k;
    endtask
    // Synthesizer settle time before any transmit data is sent
    task automatic hold_data();
        repeat (DATA_WAIT_CYC) @(posedge clk);
    endtask
endmodule

// ---- verif/rcsq_top_assertions.sv ----
// Checker for the chip control sequencer, watching top-level ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module rcsq_top_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic power_on_request,
    input wire logic bidir_data_line_o,
    input wire logic bidir_data_line_oe,
    input wire logic rx_raw_data,
    input wire logic clear_n,
    input wire logic osc_power_ctl,
    input wire logic tx_path_power,
    input wire logic amp_power,
    input wire logic rx_path_power,
    input wire logic rx_sync_clock,
    input wire logic rx_sync_data
);
    // Everything here belongs to the one clock and its reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Any of the osc, tx, amp and rx power outputs, so off checks stay short
    logic any_pwr;
    assign any_pwr = osc_power_ctl | tx_path_power | amp_power | rx_path_power;
    chk_off_forces_low: assert property (!power_on_request |-> ##2 (!clear_n && !any_pwr))
        else $error("power request low did not force everything off");
    chk_clear_all_off: assert property (!clear_n |-> !any_pwr)
        else $error("power output high while clear is asserted");
    chk_leave_off_osc: assert property ($rose(clear_n) |-> osc_power_ctl)
        else $error("clear released without oscillator power");
    chk_amp_needs_tx: assert property (amp_power |-> tx_path_power)
        else $error("amplifier powered without transmit path");
    // Transmit path must outlive the amplifier by the shutdown gap
    chk_amp_off_gap: assert property (
        $fell(amp_power) && $past(power_on_request, 2) |->
        tx_path_power [*8] ##[10:14] !tx_path_power)
        else $error("transmit path shutdown gap wrong");
    chk_rx_power_state: assert property ($rose(rx_path_power) |-> $past(bidir_data_line_oe))
        else $error("receive path powered outside receive data");
    chk_rx_data_out: assert property (bidir_data_line_oe |-> bidir_data_line_o == rx_raw_data)
        else $error("data line does not carry received data");
    chk_sync_clk_run: assert property (
        bidir_data_line_oe && $past(bidir_data_line_oe) &&
        $past(bidir_data_line_oe, 2) |-> rx_sync_clock != $past(rx_sync_clock))
        else $error("receive clock not toggling");
    chk_sync_clk_idle: assert property (
        !bidir_data_line_oe && !$past(bidir_data_line_oe) |-> !rx_sync_clock)
        else $error("receive clock running outside receive data");
    // Retimed data must be the raw bit seen as the receive clock falls
    chk_sync_data_take: assert property (
        bidir_data_line_oe && rx_sync_clock |=> rx_sync_data == $past(rx_raw_data))
        else $error("received data not taken as the receive clock falls");
    cover property ($rose(amp_power));
    cover property ($rose(rx_path_power));
    cover property ($rose(clear_n));
endmodule

// ---- verif/testbench.sv ----
// Bench for the chip control sequencer: scenarios as tasks, one verdict.
// Assumes the baseband model and the checker are compiled first.
`timescale 1ns/100ps
module testbench;
    import rcsq_pkg::*;
    logic clk, rst, reg_wr, reg_rd, clear_n, osc_power_ctl, tx_path_power, amp_power;
    logic rx_path_power, multiplier_power, synth_power, payload_dc_mode, rx_sync_clock;
    logic tx_loop_filter_external, rx_sync_data, power_on_request, osc_enable_request;
    logic bidir_data_line_i, bidir_data_line_o, bidir_data_line_oe, packet_control;
    logic rx_raw_data;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    int failures, samples_checked;
    // Settle counts cut to 4 cycles so power-up stays short
    rcsq_top #(.OSC_CYC(4), .SYN_CYC(4)) uut (
        .clk(clk), .rst(rst), .power_on_request(power_on_request),
        .osc_enable_request(osc_enable_request), .bidir_data_line_i(bidir_data_line_i),
        .bidir_data_line_o(bidir_data_line_o), .bidir_data_line_oe(bidir_data_line_oe),
        .packet_control(packet_control), .rx_raw_data(rx_raw_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .clear_n(clear_n), .osc_power_ctl(osc_power_ctl), .tx_path_power(tx_path_power),
        .amp_power(amp_power), .rx_path_power(rx_path_power),
        .multiplier_power(multiplier_power), .synth_power(synth_power),
        .payload_dc_mode(payload_dc_mode), .tx_loop_filter_external(tx_loop_filter_external),
        .rx_sync_data(rx_sync_data), .rx_sync_clock(rx_sync_clock));
    rcsq_bb_model bb (
        .clk(clk), .bidir_data_line_o(bidir_data_line_o),
        .bidir_data_line_oe(bidir_data_line_oe), .power_on_request(power_on_request),
        .osc_enable_request(osc_enable_request), .bidir_data_line_i(bidir_data_line_i),
        .packet_control(packet_control), .rx_raw_data(rx_raw_data));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Power outputs packed as clear, osc, tx, amp, rx
    function automatic logic [15:0] pw();
        return {11'h0, clear_n, osc_power_ctl, tx_path_power, amp_power, rx_path_power};
    endfunction
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Register write: one cycle with the strobe up
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Register read: data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Poll the state field under a bounded count, then judge it
    task automatic wait_st(input rcsq_state_e st, input int n);
        v = 16'hffff;
        for (int i = 0; i < n && v[3:0] !== st; i++)
            rd(REG_STAT, v);
        check(v[3:0], st);
        settle();
    endtask
    task automatic t_off();
        wait_st(RCSQ_OFF, 1);
        check(pw(), 16'h0);
        wr(REG_CTRL, 16'h0008);
        rd(REG_CTRL, v);
        check(v, 16'h0);
        bb.drive(1'b1, 1'b0, 1'b0, 1'b0);
        wait_st(RCSQ_OFF, 10);
    endtask
    task automatic t_up();
        bb.drive(1'b1, 1'b0, 1'b1, 1'b0);
        wait_st(RCSQ_PWR_OSC_WAIT, 20);
        check(pw(), 16'h18);
        bb.drive(1'b1, 1'b1, 1'b1, 1'b0);
        wait_st(RCSQ_IDLE, 40);
        check(pw(), 16'h18);
        check(bidir_data_line_oe, 1'b0);
    endtask
    task automatic t_sleep();
        wr(REG_CTRL, 16'h0008);
        bb.drive(1'b1, 1'b0, 1'b1, 1'b0);
        wait_st(RCSQ_SLEEP, 20);
        check(pw(), 16'h10);
        rd(REG_CTRL, v);
        check(v, 16'h0008);
        check(tx_loop_filter_external, 1'b1);
        bb.drive(1'b1, 1'b1, 1'b1, 1'b0);
        wait_st(RCSQ_IDLE, 40);
        check(pw(), 16'h18);
        wr(REG_CTRL, 16'h0000);
    endtask
    task automatic t_tx();
        bb.drive(1'b1, 1'b1, 1'b0, 1'b1);
        wr(REG_CTRL, 16'h0001);
        wait_st(RCSQ_IDLE, 1);
        wr(REG_CTRL, 16'h0000);
        bb.drive(1'b1, 1'b1, 1'b0, 1'b0);
        wr(REG_CTRL, 16'h0001);
        wait_st(RCSQ_WAIT_SYNC, 10);
        repeat (10) @(posedge clk);
        check(pw(), 16'h1c);
        bb.hold_data();
        bb.drive(1'b1, 1'b1, 1'b1, 1'b0);
        wait_st(RCSQ_DATA_SYNC, 10);
        bb.drive(1'b1, 1'b1, 1'b1, 1'b1);
        wait_st(RCSQ_TX_DATA, 10);
        check(pw(), 16'h1e);
        bb.drive(1'b1, 1'b1, 1'b1, 1'b0);
        wait_st(RCSQ_AMP_OFF, 10);
        check(pw(), 16'h1c);
        repeat (30) @(posedge clk);
        check(pw(), 16'h18);
        wr(REG_CTRL, 16'h0002);
        rd(REG_STAT, v);
        check(v[3:0], RCSQ_IDLE);
        wait_st(RCSQ_RX_PLL_WAIT, 20);
    endtask
    // Receive pass; bbc picks baseband or timer end of sync word
    task automatic t_rx(input logic bbc);
        if (bbc) begin
            wr(REG_CTRL, 16'h0006);
        end
        wait_st(RCSQ_RX_DATA, 20);
        check(pw(), 16'h19);
        check(bidir_data_line_oe, 1'b1);
        check(payload_dc_mode, 1'b0);
        check({multiplier_power, synth_power}, 2'b11);
        // Packet control high in both passes: only baseband mode may act on it at once
        bb.drive(1'b1, 1'b1, 1'b1, 1'b1);
        repeat (4) rd(REG_STAT, v);
        check(v[4], bbc);
        for (int i = 0; i < 800 && v[4] !== 1'b1; i++)
            rd(REG_STAT, v);
        settle();
        check(payload_dc_mode, 1'b1);
        bb.drive(1'b1, 1'b1, 1'b1, 1'b0);
        wr(REG_CTRL, 16'h0000);
        wait_st(RCSQ_IDLE, 10);
        check(pw(), 16'h18);
        check(synth_power, 1'b0);
    endtask
    // Calibration-style bypass steps; no PLL setting is rewritten after start-up
    task automatic t_bypass();
        wr(REG_OVR, 16'h80c1);
        settle();
        check(pw(), 16'h1c);
        check({multiplier_power, synth_power}, 2'b11);
        wr(REG_OVR, 16'h0000);
        settle();
        check(pw(), 16'h18);
    endtask
    task automatic t_drop();
        wr(REG_CTRL, 16'h0008);
        bb.drive(1'b0, 1'b1, 1'b1, 1'b0);
        wait_st(RCSQ_OFF, 10);
        check(pw(), 16'h0);
        check(tx_loop_filter_external, 1'b0);
    endtask
    // Watchdog sized well past the few thousand cycles the run needs
    initial begin
        #2000000;
        failures++;
        give_verdict();
    end
    initial begin
        failures = 0;
        samples_checked = 0;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_off();
        t_up();
        t_sleep();
        t_tx();
        t_rx(1'b0);
        t_rx(1'b1);
        t_bypass();
        t_drop();
        give_verdict();
    end
endmodule
bind rcsq_top rcsq_top_chk chk (
    .clk(clk), .rst(rst), .power_on_request(power_on_request),
    .bidir_data_line_o(bidir_data_line_o), .bidir_data_line_oe(bidir_data_line_oe),
    .rx_raw_data(rx_raw_data), .clear_n(clear_n), .osc_power_ctl(osc_power_ctl),
    .tx_path_power(tx_path_power), .amp_power(amp_power), .rx_path_power(rx_path_power),
    .rx_sync_clock(rx_sync_clock), .rx_sync_data(rx_sync_data));

// ---- verilog/rcsq_pkg.sv ----
// Constants shared by the radio chip control sequencer.
// Assumes a single 20 MHz system clock and a plain register port.
package rcsq_pkg;
    // Clock rate in kHz
    localparam int CLK_KHZ = 20000;
    // Settling and path delays in microseconds
    localparam int OSC_SETTLE_US = 500;
    localparam int SYNTH_DELAY_US = 100;
    localparam int TX_OFF_DELAY_US = 1;
    localparam int IDLE_RX_HOLD_US = 1;
    localparam int SYNC_WORD_US = 72;
    // Cycle counts, least times rounded up
    localparam int OSC_SETTLE_CYC = (OSC_SETTLE_US * CLK_KHZ + 999) / 1000;
    localparam int SYNTH_DELAY_CYC = (SYNTH_DELAY_US * CLK_KHZ + 999) / 1000;
    localparam int TX_OFF_CYC = (TX_OFF_DELAY_US * CLK_KHZ + 999) / 1000;
    localparam int IDLE_RX_CYC = (IDLE_RX_HOLD_US * CLK_KHZ + 999) / 1000;
    localparam int SYNC_WORD_CYC = (SYNC_WORD_US * CLK_KHZ + 999) / 1000;
    localparam int CNT_W = 16;
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_OVR = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam logic [3:0] REG_ID = 4'h3;
    // Control register fields
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_BBC = 2;
    localparam int CTRL_LF_EXT = 3;
    // Override register fields
    localparam int OVR_TX = 0;
    localparam int OVR_RX = 2;
    localparam int OVR_PA = 3;
    localparam int OVR_MULT = 6;
    localparam int OVR_OSC = 7;
    localparam int OVR_BYPASS = 15;
    // Arbitrary neutral identity value
    localparam logic [15:0] ID_VALUE = 16'h5a5a;
    // Sequencer states
    typedef enum logic [3:0] {
        RCSQ_OFF, RCSQ_PWR_OSC_WAIT, RCSQ_OSC_HOLD, RCSQ_IDLE, RCSQ_SLEEP,
        RCSQ_OSC_REWAKE, RCSQ_WAIT_SYNC, RCSQ_DATA_SYNC, RCSQ_AMP_ON,
        RCSQ_TX_DATA, RCSQ_AMP_OFF, RCSQ_RX_PLL_WAIT, RCSQ_RX_DATA
    } rcsq_state_e;
endpackage

// ---- verilog/rcsq_top.sv ----
// Chip control sequencer: moves the radio through its power states.
// Assumes synchronous inputs and a one-cycle read latency register port.
// Overview of operation
// - Power request low forces off, clears all
// - Off leaves when data high, osc request low
// - Settled oscillator goes hold then idle
// - Idle to sleep keeps configuration, osc off
// - Sleep wakes oscillator, waits, returns idle
// - Tx enable starts synth, delayed tx power
// - Rising data line enters data sync
// - Packet control high powers amp, tx data
// - Packet low drops amp then tx path
// - Pending rx after amp off holds idle
// - Rx enable starts synth, delayed rx power
// - Rx data output with estimation mode
// - Sync end by timer or packet control
// - Clearing rx enable returns to idle
// - Operation independent of exact clock rate
// - Illegal transitions keep present state
// - Clear erases calibration, baseband recalibrates
// - Bypass makes powers follow override bits
// - Device acts on rising clock edges
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module rcsq_top
    import rcsq_pkg::*;
#(
    parameter int OSC_CYC = OSC_SETTLE_CYC,
    parameter int SYN_CYC = SYNTH_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic power_on_request,
    input wire logic osc_enable_request,
    input wire logic bidir_data_line_i,
    output logic bidir_data_line_o,
    output logic bidir_data_line_oe,
    input wire logic packet_control,
    input wire logic rx_raw_data,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic clear_n,
    output logic osc_power_ctl,
    output logic tx_path_power,
    output logic amp_power,
    output logic rx_path_power,
    output logic multiplier_power,
    output logic synth_power,
    output logic payload_dc_mode,
    output logic tx_loop_filter_external,
    output logic rx_sync_data,
    output logic rx_sync_clock
);
    // Elaboration checks on the counts
    if (OSC_CYC < 1 || OSC_CYC >= (1 << CNT_W)) begin : g_chk_osc
        $error("OSC_CYC out of range");
    end
    if (SYN_CYC < 1 || SYN_CYC >= (1 << CNT_W)) begin : g_chk_syn
        $error("SYN_CYC out of range");
    end

    rcsq_state_e state_r; // Present state
    rcsq_state_e state_nxt; // Next state
    logic [CNT_W-1:0] cnt_r; // Shared delay timer
    logic tx_en_r; // Transmit enable bit
    logic rx_en_r; // Receive enable bit
    logic bbc_r; // Baseband marks sync end
    logic lf_ext_r; // Loop filter test connection
    logic [15:0] ovr_r; // Bypass override bits
    logic data_q_r; // Last data line sample
    logic rx_hold_r; // Idle hold toward receive pending
    logic tx_pwr_r; // Sequencer transmit path power
    logic rx_pwr_r; // Sequencer receive path power
    logic payload_r; // Estimation mode flag
    logic [15:0] rdata_r; // Read data register
    logic [15:0] rd_mux; // Read data next value
    logic rx_clk_r; // Receive clock divider
    logic timer_done; // Timer expired
    logic cnt_load; // Timer restart on state change
    logic [CNT_W-1:0] cnt_init; // Timer start value

    assign timer_done = (cnt_r == '0);
    assign cnt_load = (state_nxt != state_r);

    // Next-state logic; unlisted input combinations hold the state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RCSQ_OFF: begin
                if (!osc_enable_request && bidir_data_line_i) begin
                    state_nxt = RCSQ_PWR_OSC_WAIT;
                end
            end
            RCSQ_PWR_OSC_WAIT: begin
                if (timer_done && osc_enable_request) begin
                    state_nxt = RCSQ_OSC_HOLD;
                end
            end
            RCSQ_OSC_HOLD: begin
                if (osc_enable_request) begin
                    state_nxt = RCSQ_IDLE;
                end
            end
            RCSQ_IDLE: begin
                if (!osc_enable_request) begin
                    state_nxt = RCSQ_SLEEP;
                end else if (rx_hold_r) begin
                    if (timer_done) begin
                        state_nxt = RCSQ_RX_PLL_WAIT;
                    end
                end else if (tx_en_r && !rx_en_r && !packet_control) begin
                    state_nxt = RCSQ_WAIT_SYNC;
                end else if (rx_en_r && !tx_en_r) begin
                    state_nxt = RCSQ_RX_PLL_WAIT;
                end
            end
            RCSQ_SLEEP: begin
                if (osc_enable_request) begin
                    state_nxt = RCSQ_OSC_REWAKE;
                end
            end
            RCSQ_OSC_REWAKE: begin
                if (timer_done) begin
                    state_nxt = RCSQ_IDLE;
                end
            end
            RCSQ_WAIT_SYNC: begin
                if (!packet_control && bidir_data_line_i && !data_q_r) begin
                    state_nxt = RCSQ_DATA_SYNC;
                end else if (!tx_en_r) begin
                    state_nxt = RCSQ_IDLE;
                end
            end
            RCSQ_DATA_SYNC: begin
                if (packet_control) begin
                    state_nxt = RCSQ_AMP_ON;
                end
            end
            RCSQ_AMP_ON: begin
                if (packet_control) begin
                    state_nxt = RCSQ_TX_DATA;
                end
            end
            RCSQ_TX_DATA: begin
                if (!packet_control) begin
                    state_nxt = RCSQ_AMP_OFF;
                end
            end
            RCSQ_AMP_OFF: begin
                if (!tx_en_r && timer_done) begin
                    state_nxt = RCSQ_IDLE;
                end
            end
            RCSQ_RX_PLL_WAIT: begin
                if (timer_done) begin
                    state_nxt = RCSQ_RX_DATA;
                end else if (!rx_en_r) begin
                    state_nxt = RCSQ_IDLE;
                end
            end
            RCSQ_RX_DATA: begin
                if (!rx_en_r) begin
                    state_nxt = RCSQ_IDLE;
                end
            end
            default: state_nxt = RCSQ_OFF;
        endcase
        // Sleep from active states leaves the enable bits in force
        if (!osc_enable_request && state_r != RCSQ_OFF &&
            state_r != RCSQ_PWR_OSC_WAIT && state_r != RCSQ_OSC_HOLD) begin
            state_nxt = RCSQ_SLEEP;
        end
        if (!power_on_request) begin
            state_nxt = RCSQ_OFF;
        end
    end

    // Timer start value for each entered state
    always_comb begin
        case (state_nxt)
            RCSQ_PWR_OSC_WAIT: cnt_init = CNT_W'(OSC_CYC - 1);
            RCSQ_OSC_REWAKE: cnt_init = CNT_W'(OSC_CYC - 1);
            RCSQ_WAIT_SYNC: cnt_init = CNT_W'(SYN_CYC - 1);
            RCSQ_RX_PLL_WAIT: cnt_init = CNT_W'(SYN_CYC - 1);
            RCSQ_AMP_OFF: cnt_init = CNT_W'(TX_OFF_CYC - 1);
            RCSQ_IDLE: cnt_init = CNT_W'(IDLE_RX_CYC - 1);
            RCSQ_RX_DATA: cnt_init = CNT_W'(SYNC_WORD_CYC - 1);
            default: cnt_init = '0;
        endcase
    end

    // State register; counts are in cycles so the rate only scales delays
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= RCSQ_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Shared timer, reloaded on every state change
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (cnt_load) begin
            cnt_r <= cnt_init;
        end else if (!timer_done) begin
            cnt_r <= cnt_r - CNT_W'(1);
        end
    end

    // Pending receive hold after amplifier shutdown
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_hold_r <= 1'b0;
        end else if (state_r == RCSQ_AMP_OFF && state_nxt == RCSQ_IDLE) begin
            rx_hold_r <= rx_en_r;
        end else if (state_nxt != RCSQ_IDLE) begin
            rx_hold_r <= 1'b0;
        end
    end

    // Data line edge detector for sync start
    always_ff @(posedge clk) begin
        if (rst) begin
            data_q_r <= 1'b0;
        end else begin
            data_q_r <= bidir_data_line_i;
        end
    end

    // Control registers; the off state wipes configuration
    always_ff @(posedge clk) begin
        if (rst || state_r == RCSQ_OFF) begin
            tx_en_r <= 1'b0;
            rx_en_r <= 1'b0;
            bbc_r <= 1'b0;
            lf_ext_r <= 1'b0;
            ovr_r <= '0;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                tx_en_r <= reg_wdata[CTRL_TX_EN];
                rx_en_r <= reg_wdata[CTRL_RX_EN];
                bbc_r <= reg_wdata[CTRL_BBC];
                lf_ext_r <= reg_wdata[CTRL_LF_EXT];
            end else if (reg_addr == REG_OVR) begin
                ovr_r <= reg_wdata;
            end
        end
    end

    // Delayed path powers from the sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_pwr_r <= 1'b0;
            rx_pwr_r <= 1'b0;
        end else begin
            case (state_nxt)
                RCSQ_WAIT_SYNC: tx_pwr_r <= (state_r == RCSQ_WAIT_SYNC) && timer_done;
                RCSQ_DATA_SYNC, RCSQ_AMP_ON, RCSQ_TX_DATA: tx_pwr_r <= 1'b1;
                RCSQ_AMP_OFF: tx_pwr_r <= (state_r == RCSQ_TX_DATA) || !timer_done;
                RCSQ_SLEEP: tx_pwr_r <= tx_pwr_r && tx_en_r;
                default: tx_pwr_r <= 1'b0;
            endcase
            case (state_nxt)
                RCSQ_RX_PLL_WAIT: rx_pwr_r <= timer_done && (state_r == state_nxt);
                RCSQ_RX_DATA: rx_pwr_r <= 1'b1;
                RCSQ_SLEEP: rx_pwr_r <= rx_pwr_r && rx_en_r;
                default: rx_pwr_r <= 1'b0;
            endcase
        end
    end

    // Estimation mode: fast until sync word ends
    always_ff @(posedge clk) begin
        if (rst || state_r != RCSQ_RX_DATA) begin
            payload_r <= 1'b0;
        end else if (bbc_r ? packet_control : timer_done) begin
            payload_r <= 1'b1;
        end
    end

    // Receive data retimed with a divided clock, launched on its falling edge
    always_ff @(posedge clk) begin
        if (rst || state_r != RCSQ_RX_DATA) begin
            rx_clk_r <= 1'b0;
            rx_sync_data <= 1'b0;
        end else begin
            rx_clk_r <= !rx_clk_r;
            if (rx_clk_r) begin
                rx_sync_data <= rx_raw_data;
            end
        end
    end

    // Power and clear outputs, overridden under bypass
    always_ff @(posedge clk) begin
        if (rst) begin
            clear_n <= 1'b0;
            osc_power_ctl <= 1'b0;
            tx_path_power <= 1'b0;
            amp_power <= 1'b0;
            rx_path_power <= 1'b0;
            multiplier_power <= 1'b0;
            synth_power <= 1'b0;
        end else if (ovr_r[OVR_BYPASS] && state_r != RCSQ_OFF) begin
            clear_n <= 1'b1;
            osc_power_ctl <= ovr_r[OVR_OSC];
            tx_path_power <= ovr_r[OVR_TX];
            amp_power <= ovr_r[OVR_PA];
            rx_path_power <= ovr_r[OVR_RX];
            multiplier_power <= ovr_r[OVR_MULT];
            synth_power <= ovr_r[OVR_TX] | ovr_r[OVR_RX];
        end else begin
            clear_n <= (state_r != RCSQ_OFF);
            osc_power_ctl <= (state_r != RCSQ_OFF) && (state_r != RCSQ_SLEEP);
            tx_path_power <= tx_pwr_r;
            amp_power <= (state_r == RCSQ_AMP_ON) || (state_r == RCSQ_TX_DATA);
            rx_path_power <= rx_pwr_r;
            multiplier_power <= (state_r == RCSQ_RX_DATA);
            synth_power <= (state_r >= RCSQ_WAIT_SYNC && state_r != RCSQ_AMP_OFF) ||
                           (state_r == RCSQ_AMP_OFF && !timer_done);
        end
    end

    // Data line drive and derived outputs
    assign bidir_data_line_o = rx_raw_data;
    assign bidir_data_line_oe = (state_r == RCSQ_RX_DATA);
    assign rx_sync_clock = rx_clk_r;
    assign payload_dc_mode = payload_r;
    assign tx_loop_filter_external = lf_ext_r;

    // Read decode
    always_comb begin
        if (reg_addr == REG_CTRL) begin
            rd_mux = {12'h000, lf_ext_r, bbc_r, rx_en_r, tx_en_r};
        end else if (reg_addr == REG_OVR) begin
            rd_mux = ovr_r;
        end else if (reg_addr == REG_STAT) begin
            rd_mux = {11'h000, payload_r, 4'(state_r)};
        end else if (reg_addr == REG_ID) begin
            rd_mux = ID_VALUE;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rd_mux;
        end
    end
    assign reg_rdata = rdata_r;
endmodule
